/* pkg/icc_defines.vh */
// Constants for the interlocked cycle counter block: bus map, field layout,
// counter states and timing. Assumes a 50 MHz REF_CLK and a 32-bit APB bus.
//
// Behaviour
// - When the change/delay counter stands at 11 and a sequence wants attention, set the change interlock and clear delay select.
// - A change-of-sequence cycle clears the change interlock, sets index busy and starts the index write counter.
// - The index write counter clears index busy when it reaches state 02.
// - The instruction counter starts as soon as index busy clears, if its other start conditions already hold.
// - A store transfer instruction sets index busy and starts the index write counter during its instruction cycle.
// - The instruction counter sets the operand request at 22, and the operand counter then starts once its conditions hold.
// - For a store transfer, the conditions that start the operand counter also start the arithmetic counter.
// - The operand counter clears the operand request on starting while the instruction counter finishes its cycle.
// - With the hold bit set, the next instruction of the sequence starts at once with no delay pause if its start interlock holds.
// - A dismissing instruction leaves the instruction counter resting at 00 while delay cycles decide.
// - A jump has no operand cycle and with configuration bits 2 and 5 dismisses and starts an index write at 31.
// - At 31, delay select is set when hold is zero, no attention is requested and dismissal is requested.
// - Setting delay select places the change/delay counter in its delay resting state 08.
// - Delay cycles wait for the index write counter to rest, then repeat until a sequence wants attention.
// - The change-of-sequence counter starts only when every one of its listed interlock conditions holds.
// - The delay counter counts only with delay select set, index write resting and the instruction counter at 02, 23 or 00.
`ifndef ICC_DEFINES_VH
`define ICC_DEFINES_VH

// Register byte offsets.
`define ICC_OFS_INSTR   8'h00
`define ICC_OFS_STATES  8'h04
`define ICC_OFS_FLAGS   8'h08

// Instruction register fields.
`define ICC_B_HOLD      0
`define ICC_B_CF5       1
`define ICC_B_CF2       2
`define ICC_B_STORE     3
`define ICC_B_JUMP      4
`define ICC_B_AUX       5
`define ICC_IR_W        6

// Flag register fields.
`define ICC_B_XB        0
`define ICC_B_XW        1
`define ICC_B_PI1       2
`define ICC_B_PI3       3
`define ICC_B_DSEL      4
`define ICC_B_PEND      5

// Counter states.
`define ICC_S00         5'h00
`define ICC_S01         5'h01
`define ICC_S02         5'h02
`define ICC_S04         5'h04
`define ICC_S07         5'h07
`define ICC_S08         5'h08
`define ICC_S09         5'h09
`define ICC_S11         5'h0B
`define ICC_S14         5'h0E
`define ICC_S22         5'h16
`define ICC_S23         5'h17
`define ICC_S24         5'h18
`define ICC_S31         5'h1F
`define ICC_XWK_LAST    5'h03

// Timing pulse period and its cycle count.
`define ICC_CLK_NS      20
`define ICC_TICK_NS     400
`define ICC_TICK_CYC    (`ICC_TICK_NS / `ICC_CLK_NS)
`define ICC_DIV_W       5

`endif

/* core/icc_counter.v */
// One cycle counter of the control element: rests, starts, counts on the
// timing pulse and wraps. Assumes the caller supplies the rest, first, last
// and wrap states and a one-cycle timing pulse on the same clock.
`timescale 1ns/10ps
`include "icc_defines.vh"

module icc_counter (
   input  wire       clk,        // System clock.
   input  wire       arst_n,     // Asynchronous reset, active low.
   input  wire       tick,       // Timing pulse enable.
   input  wire       start,      // Leave the rest state.
   input  wire       run,        // Permission to advance past rest.
   input  wire       load,       // Force the state to load_val.
   input  wire [4:0] load_val,   // Forced state.
   input  wire [4:0] rest_val,   // Resting state.
   input  wire [4:0] first_val,  // State entered on start.
   input  wire [4:0] last_val,   // Last state of a cycle.
   input  wire [4:0] wrap_val,   // State after the last one.
   output reg  [4:0] state_r     // Present state.
);

   reg [4:0] state_nxt;

   // Next state: a forced load overrides counting.
   always @* begin
      state_nxt = state_r;
      if (load) begin
         state_nxt = load_val;
      end else if (tick) begin
         if (state_r == rest_val) begin
            if (start) begin
               state_nxt = first_val;
            end
         end else if (run) begin
            if (state_r == last_val) begin
               state_nxt = wrap_val;
            end else begin
               state_nxt = state_r + 5'h01;
            end
         end
      end
   end

   // State register.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= `ICC_S00;
      end else begin
         state_r <= state_nxt;
      end
   end

endmodule

/* core/icc_top.v */
// Interlocked sequencing of the instruction, operand, change/delay, index
// write, arithmetic and auxiliary cycle counters, with an APB register port.
// Assumes all pin inputs are synchronous to REF_CLK and the APB master keeps
// its request steady until PREADY is sampled high.
`timescale 1ns/10ps
`include "icc_defines.vh"

module icc_top (
   input  wire        REF_CLK,                // 50 MHz system clock.
   input  wire        ARST_N,                 // Asynchronous reset, active low.
   input  wire        PSEL,                   // APB select.
   input  wire        PENABLE,                // APB access phase.
   input  wire        PWRITE,                 // APB write direction.
   input  wire [7:0]  PADDR,                  // APB byte address.
   input  wire [31:0] PWDATA,                 // APB write data.
   output reg  [31:0] PRDATA,                 // APB read data.
   output reg         PREADY,                 // APB transfer done.
   output reg         PSLVERR,                // APB unmapped address.
   input  wire        SEQ_ATT_REQ,            // Sequence attention request.
   input  wire        RUN_SYNC,               // Run synchronizer level.
   input  wire        E_REG_BUSY,             // E register busy flag.
   output reg  [4:0]  INSTR_CYCLE_STATE,      // Instruction counter state.
   output reg  [4:0]  OPERAND_CYCLE_STATE,    // Operand counter state.
   output reg         INDEX_MEMORY_BUSY,      // Index memory busy flag.
   output reg         DELAY_SELECT            // Delay select bit.
);

   // True when an APB address hits one of the three registers.
   function addr_hit;
      input [7:0] a;
      begin
         addr_hit = (a == `ICC_OFS_INSTR) || (a == `ICC_OFS_STATES) ||
                    (a == `ICC_OFS_FLAGS);
      end
   endfunction

   reg [`ICC_DIV_W-1:0] div_r;
   reg                  tick_r;
   reg [`ICC_IR_W-1:0]  next_ir_r;
   reg [`ICC_IR_W-1:0]  ir_r;
   reg                  pend_r;
   reg                  op_req_r;
   reg                  seq_chg_r;
   reg                  dsel_r;
   reg                  xbusy_r;
   reg                  xwrite_r;
   reg [31:0]           rd_nxt;

   wire [4:0] pk;
   wire [4:0] qk;
   wire [4:0] csk;
   wire [4:0] index_memory_write_counter;
   wire [4:0] fk;
   wire [4:0] ak;

   wire apb_req;
   wire apb_wr;
   wire pk_ok;
   wire pk_go;
   wire pk_wrap_go;
   wire qk_go;
   wire fk_go;
   wire ak_go;
   wire csk_go;
   wire dsk_ok;
   wire xwk_go;
   wire at_csk04;
   wire at_csk11_att;
   wire at_pk14_store;
   wire at_pk22;
   wire at_pk31;
   wire dsel_set;
   wire seq_chg_set;
   wire xb_clr;

   // Timing pulse divider: one tick each ICC_TICK_CYC clocks.
   always @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         div_r  <= {`ICC_DIV_W{1'b0}};
         tick_r <= 1'b0;
      end else begin
         if (div_r == `ICC_TICK_CYC - 1) begin
            div_r  <= {`ICC_DIV_W{1'b0}};
            tick_r <= 1'b1;
         end else begin
            div_r  <= div_r + 1'b1;
            tick_r <= 1'b0;
         end
      end
   end

   // Named moments on the timing pulse.
   assign at_csk04      = tick_r && !dsel_r && (csk == `ICC_S04);
   assign at_csk11_att  = tick_r && dsel_r && (csk == `ICC_S11) && SEQ_ATT_REQ;
   assign at_pk14_store = tick_r && (pk == `ICC_S14) && ir_r[`ICC_B_STORE];
   assign at_pk22       = tick_r && (pk == `ICC_S22) && !ir_r[`ICC_B_JUMP];
   assign at_pk31       = tick_r && (pk == `ICC_S31);

   // Delay select decided at the end of an instruction; sequence change there or at delay state 11.
   assign dsel_set    = at_pk31 && !ir_r[`ICC_B_HOLD] && !SEQ_ATT_REQ && ir_r[`ICC_B_CF5];
   assign seq_chg_set = at_csk11_att || (at_pk31 && !ir_r[`ICC_B_HOLD] && SEQ_ATT_REQ);

   // Instruction start interlock: all quiet, a word waiting and the run level present.
   // A change cycle holds the counter off until it has claimed the index memory at 04.
   assign pk_ok = pend_r && !op_req_r && !seq_chg_r && !dsel_r && !xbusy_r && RUN_SYNC &&
                  ((csk == `ICC_S00) || (csk > `ICC_S04));
   assign pk_go = tick_r && (pk == `ICC_S00) && pk_ok;

   // With hold, the next instruction follows straight from 31 when the interlock holds.
   assign pk_wrap_go = at_pk31 && ir_r[`ICC_B_HOLD] && pk_ok;

   // Operand counter starts once the request is up; arithmetic counter joins for a store.
   assign qk_go = tick_r && (qk == `ICC_S00) && op_req_r && RUN_SYNC;
   assign fk_go = qk_go && ir_r[`ICC_B_STORE];
   assign ak_go = tick_r && (qk == `ICC_S14) && ir_r[`ICC_B_AUX];

   // Change-of-sequence start interlock.
   assign csk_go = tick_r && (pk == `ICC_S00) && !op_req_r && !dsel_r && seq_chg_r &&
                   !xwrite_r && !xbusy_r && !E_REG_BUSY && RUN_SYNC;

   // Delay counting needs index write at rest and the instruction counter waiting.
   assign dsk_ok = dsel_r && (index_memory_write_counter == `ICC_S00) &&
                   ((pk == `ICC_S02) || (pk == `ICC_S23) || (pk == `ICC_S00));

   // Index write counter starts from a sequence change, a store or a jump at 31.
   assign xwk_go = at_csk04 || at_pk14_store ||
                   (at_pk31 && ir_r[`ICC_B_JUMP] && ir_r[`ICC_B_CF2]);
   assign xb_clr = tick_r && (index_memory_write_counter == `ICC_S02);

   // Instruction counter.
   icc_counter u_pk (
      .clk       (REF_CLK),
      .arst_n    (ARST_N),
      .tick      (tick_r),
      .start     (pk_go),
      .run       (1'b1),
      .load      (1'b0),
      .load_val  (`ICC_S00),
      .rest_val  (`ICC_S00),
      .first_val (`ICC_S01),
      .last_val  (`ICC_S31),
      .wrap_val  (pk_wrap_go ? `ICC_S01 : `ICC_S00),
      .state_r   (pk)
   );

   // Operand counter.
   icc_counter u_qk (
      .clk       (REF_CLK),
      .arst_n    (ARST_N),
      .tick      (tick_r),
      .start     (qk_go),
      .run       (1'b1),
      .load      (1'b0),
      .load_val  (`ICC_S00),
      .rest_val  (`ICC_S00),
      .first_val (`ICC_S01),
      .last_val  (`ICC_S24),
      .wrap_val  (`ICC_S00),
      .state_r   (qk)
   );

   // Change-of-sequence counter; in delay mode it rests at 08 and loops 09 to 11.
   icc_counter u_csk (
      .clk       (REF_CLK),
      .arst_n    (ARST_N),
      .tick      (tick_r),
      .start     (dsel_r ? dsk_ok : csk_go),
      .run       (dsel_r ? dsk_ok : 1'b1),
      .load      (dsel_set || at_csk11_att),
      .load_val  (dsel_set ? `ICC_S08 : `ICC_S00),
      .rest_val  (dsel_r ? `ICC_S08 : `ICC_S00),
      .first_val (dsel_r ? `ICC_S09 : `ICC_S01),
      .last_val  (dsel_r ? `ICC_S11 : `ICC_S07),
      .wrap_val  (dsel_r ? `ICC_S08 : `ICC_S00),
      .state_r   (csk)
   );

   // Index memory write counter.
   icc_counter u_xwk (
      .clk       (REF_CLK),
      .arst_n    (ARST_N),
      .tick      (tick_r),
      .start     (xwk_go),
      .run       (1'b1),
      .load      (1'b0),
      .load_val  (`ICC_S00),
      .rest_val  (`ICC_S00),
      .first_val (`ICC_S01),
      .last_val  (`ICC_XWK_LAST),
      .wrap_val  (`ICC_S00),
      .state_r   (index_memory_write_counter)
   );

   // Arithmetic element counter.
   icc_counter u_fk (
      .clk       (REF_CLK),
      .arst_n    (ARST_N),
      .tick      (tick_r),
      .start     (fk_go),
      .run       (1'b1),
      .load      (1'b0),
      .load_val  (`ICC_S00),
      .rest_val  (`ICC_S00),
      .first_val (`ICC_S01),
      .last_val  (`ICC_S07),
      .wrap_val  (`ICC_S00),
      .state_r   (fk)
   );

   // Auxiliary counter.
   icc_counter u_ak (
      .clk       (REF_CLK),
      .arst_n    (ARST_N),
      .tick      (tick_r),
      .start     (ak_go),
      .run       (1'b1),
      .load      (1'b0),
      .load_val  (`ICC_S00),
      .rest_val  (`ICC_S00),
      .first_val (`ICC_S01),
      .last_val  (`ICC_S07),
      .wrap_val  (`ICC_S00),
      .state_r   (ak)
   );

   // Interlock flags; in each one a set in the same cycle wins over a clear.
   always @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         op_req_r  <= 1'b0;
         seq_chg_r <= 1'b0;
         dsel_r    <= 1'b0;
         xbusy_r   <= 1'b0;
         xwrite_r  <= 1'b0;
      end else begin
         // Operand request: raised at 22, dropped as the operand counter starts.
         if (at_pk22) begin
            op_req_r <= 1'b1;
         end else if (qk_go) begin
            op_req_r <= 1'b0;
         end
         // Sequence change interlock: dropped as the change cycle starts.
         if (seq_chg_set) begin
            seq_chg_r <= 1'b1;
         end else if (csk_go) begin
            seq_chg_r <= 1'b0;
         end
         // Delay select: set on dismissal, cleared on a sampled attention request.
         if (dsel_set) begin
            dsel_r <= 1'b1;
         end else if (at_csk11_att) begin
            dsel_r <= 1'b0;
         end
         // Index memory busy: set by its users, cleared by the write counter at 02.
         if (at_csk04 || at_pk14_store) begin
            xbusy_r <= 1'b1;
         end else if (xb_clr) begin
            xbusy_r <= 1'b0;
         end
         // Index write: covers the whole write counter cycle.
         if (xwk_go) begin
            xwrite_r <= 1'b1;
         end else if (tick_r && (index_memory_write_counter == `ICC_XWK_LAST)) begin
            xwrite_r <= 1'b0;
         end
      end
   end

   // APB handshake terms: one wait state, writes land when PREADY is high.
   assign apb_req = PSEL && PENABLE;
   assign apb_wr  = apb_req && PREADY && PWRITE && (PADDR == `ICC_OFS_INSTR);

   // Instruction word: software loads the next word, the counter takes it on start.
   always @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         next_ir_r <= {`ICC_IR_W{1'b0}};
         ir_r      <= {`ICC_IR_W{1'b0}};
         pend_r    <= 1'b0;
      end else begin
         if (pk_go || pk_wrap_go) begin
            ir_r <= next_ir_r;
         end
         // A new write in the cycle the word is taken keeps the pending flag up.
         if (apb_wr) begin
            next_ir_r <= PWDATA[`ICC_IR_W-1:0];
            pend_r    <= 1'b1;
         end else if (pk_go || pk_wrap_go) begin
            pend_r <= 1'b0;
         end
      end
   end

   // Read data mux for the three registers; unmapped reads return zero.
   always @* begin
      rd_nxt = 32'h00000000;
      case (PADDR)
         `ICC_OFS_INSTR: begin
            rd_nxt[`ICC_IR_W-1:0] = next_ir_r;
         end
         `ICC_OFS_STATES: begin
            rd_nxt[29:0] = {ak, fk, index_memory_write_counter, csk, qk, pk};
         end
         `ICC_OFS_FLAGS: begin
            rd_nxt[`ICC_B_XB]   = xbusy_r;
            rd_nxt[`ICC_B_XW]   = xwrite_r;
            rd_nxt[`ICC_B_PI1]  = op_req_r;
            rd_nxt[`ICC_B_PI3]  = seq_chg_r;
            rd_nxt[`ICC_B_DSEL] = dsel_r;
            rd_nxt[`ICC_B_PEND] = pend_r;
         end
         default: begin
            rd_nxt = 32'h00000000;
         end
      endcase
   end

   // APB answer registers: PREADY rises in the second access cycle.
   always @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA  <= 32'h00000000;
      end else begin
         PREADY  <= apb_req && !PREADY;
         PSLVERR <= apb_req && !PREADY && !addr_hit(PADDR);
         if (apb_req && !PREADY && !PWRITE) begin
            PRDATA <= rd_nxt;
         end
      end
   end

   // Visible state outputs, each held in a flop.
   always @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         INSTR_CYCLE_STATE   <= `ICC_S00;
         OPERAND_CYCLE_STATE <= `ICC_S00;
         INDEX_MEMORY_BUSY   <= 1'b0;
         DELAY_SELECT        <= 1'b0;
      end else begin
         INSTR_CYCLE_STATE   <= pk;
         OPERAND_CYCLE_STATE <= qk;
         INDEX_MEMORY_BUSY   <= xbusy_r;
         DELAY_SELECT        <= dsel_r;
      end
   end

endmodule

/* testbench/icc_asserts.sv */
// Checker for the counter and interlock outputs of icc_top.
// Assumes one clock, REF_CLK, and the asynchronous reset ARST_N.
`timescale 1ns/10ps
`include "icc_defines.vh"

module icc_asserts (
   input wire       REF_CLK,              // Clock.
   input wire       ARST_N,               // Reset, active low.
   input wire       SEQ_ATT_REQ,          // Attention request.
   input wire       RUN_SYNC,             // Run level.
   input wire [4:0] INSTR_CYCLE_STATE,    // Instruction state.
   input wire [4:0] OPERAND_CYCLE_STATE,  // Operand state.
   input wire       INDEX_MEMORY_BUSY,    // Index busy.
   input wire       DELAY_SELECT          // Delay select.
);
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!ARST_N);

   // Busy must stay up for 8 clocks after rising, then clear 11 to 45 clocks later.
   sequence busy_held_s;
      INDEX_MEMORY_BUSY [*8];
   endsequence
   sequence busy_free_s;
      !INDEX_MEMORY_BUSY;
   endsequence

   busy_release_a: assert property ($rose(INDEX_MEMORY_BUSY) |-> busy_held_s ##[11:45] busy_free_s)
      else $error("index busy not released in time");
   busy_source_a: assert property ($rose(INDEX_MEMORY_BUSY) |->
      INSTR_CYCLE_STATE inside {`ICC_S00, [5'h0D:5'h0F]})
      else $error("index busy raised at a wrong instruction state");
   op_start_a: assert property ($past(OPERAND_CYCLE_STATE) == `ICC_S00 && OPERAND_CYCLE_STATE != `ICC_S00 |->
      INSTR_CYCLE_STATE inside {[`ICC_S22:`ICC_S24]})
      else $error("operand counter started away from the request");
   instr_step_a: assert property ($changed(INSTR_CYCLE_STATE) && !($past(INSTR_CYCLE_STATE) inside {`ICC_S00, `ICC_S31})
      |-> INSTR_CYCLE_STATE == $past(INSTR_CYCLE_STATE) + 5'h01)
      else $error("instruction counter skipped a state");
   instr_wrap_a: assert property ($past(INSTR_CYCLE_STATE) == `ICC_S31 && INSTR_CYCLE_STATE != `ICC_S31
      |-> INSTR_CYCLE_STATE inside {`ICC_S00, `ICC_S01})
      else $error("instruction counter left 31 wrongly");
   dsel_rest_a: assert property (DELAY_SELECT && INSTR_CYCLE_STATE == `ICC_S00 |=> INSTR_CYCLE_STATE == `ICC_S00)
      else $error("instruction started during delay select");
   dsel_set_a: assert property ($rose(DELAY_SELECT) |->
      INSTR_CYCLE_STATE inside {`ICC_S31, `ICC_S00} && !$past(SEQ_ATT_REQ, 2))
      else $error("delay select set without a dismissal at 31");
   dsel_clear_a: assert property ($fell(DELAY_SELECT) |-> $past(SEQ_ATT_REQ, 2))
      else $error("delay select cleared without attention");
   instr_gate_a: assert property ($past(INSTR_CYCLE_STATE) == `ICC_S00 && INSTR_CYCLE_STATE == `ICC_S01 |->
      $past(RUN_SYNC, 2) && !$past(INDEX_MEMORY_BUSY, 2) && !$past(DELAY_SELECT, 2))
      else $error("instruction started against its interlocks");
endmodule

bind icc_top icc_asserts i_chk (.REF_CLK, .ARST_N, .SEQ_ATT_REQ, .RUN_SYNC, .INSTR_CYCLE_STATE,
   .OPERAND_CYCLE_STATE, .INDEX_MEMORY_BUSY, .DELAY_SELECT);

/* testbench/icc_sel_model.sv */
// Model of the sequence selector flags, E register and run level.
// Assumes the bench changes each command just after a rising edge.
`timescale 1ns/10ps

module icc_sel_model (
   input  wire clk,        // Clock.
   input  wire arst_n,     // Reset, active low.
   input  wire att_cmd,    // Attention wanted.
   input  wire ebusy_cmd,  // E register held.
   input  wire run_cmd,    // Machine may run.
   output reg  att_req,    // Attention, three clocks late.
   output reg  e_busy,     // E register busy.
   output reg  run_lvl     // Run level.
);
   reg [1:0] att_dly_r;

   // Attention crawls through the selector; the other levels answer promptly.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         att_dly_r <= 2'b00;
         att_req   <= 1'b0;
         e_busy    <= 1'b0;
         run_lvl   <= 1'b0;
      end else begin
         att_dly_r <= {att_dly_r[0], att_cmd};
         att_req   <= att_dly_r[1];
         e_busy    <= ebusy_cmd;
         run_lvl   <= run_cmd;
      end
   end
endmodule

/* testbench/tb_interlocked_cycle_counters.sv */
// Self-checking bench for icc_top: APB master, interlock stimulus, verdict.
// Assumes the selector model drives attention, E busy and run level.
`timescale 1ns/10ps
`include "icc_defines.vh"

module tb_interlocked_cycle_counters;
   reg         REF_CLK, ARST_N, psel, penable, pwrite, er, att, ebusy, run, op_seen;
   reg  [7:0]  paddr;
   reg  [31:0] pwdata, rd, w;
   wire [31:0] prdata;
   wire        pready, pslverr, att_req, e_busy, run_lvl, busy, dsel;
   wire [4:0]  ist, ost;
   integer     err_total, cmp_count, seed, n, k;

   icc_top i_dut (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .SEQ_ATT_REQ(att_req), .RUN_SYNC(run_lvl), .E_REG_BUSY(e_busy), .INSTR_CYCLE_STATE(ist),
      .OPERAND_CYCLE_STATE(ost), .INDEX_MEMORY_BUSY(busy), .DELAY_SELECT(dsel));
   icc_sel_model i_sel (.clk(REF_CLK), .arst_n(ARST_N), .att_cmd(att), .ebusy_cmd(ebusy),
      .run_cmd(run), .att_req(att_req), .e_busy(e_busy), .run_lvl(run_lvl));

   // Free-running 50 MHz clock.
   initial begin
      REF_CLK = 1'b0;
      forever #10 REF_CLK = ~REF_CLK;
   end

   // Prints the verdict and ends the run.
   task summarize;
      begin
         if (err_total == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask

   // Counts one comparison and reports a mismatch.
   task chk(input [31:0] g, input [31:0] e);
      begin
         cmp_count = cmp_count + 1;
         if (g !== e) begin
            err_total = err_total + 1;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
         end
      end
   endtask

   // A spent wait bound is a mismatch and closes the run.
   task give_up;
      begin
         err_total = err_total + 1;
         summarize;
      end
   endtask

   // Only the low six bits of an instruction word are kept.
   function [31:0] exp_instr(input [31:0] v);
      exp_instr = {26'h0, v[5:0]};
   endfunction

   // Selects an observed output for the wait task.
   function [4:0] probe(input integer sel);
      probe = sel == 0 ? ist : sel == 1 ? {4'h0, busy} : {4'h0, dsel};
   endfunction

   // One APB transfer; data and error are taken at the edge PREADY is sampled high.
   task apb(input wr, input [7:0] a, input [31:0] d);
      begin
         @(posedge REF_CLK);
         psel    <= 1'b1;
         penable <= 1'b0;
         pwrite  <= wr;
         paddr   <= a;
         pwdata  <= d;
         @(posedge REF_CLK);
         penable <= 1'b1;
         n = 0;
         do begin
            @(posedge REF_CLK);
            n = n + 1;
         end while (pready !== 1'b1 && n < 40);
         if (pready !== 1'b1)
            give_up;
         rd = prdata;
         er = pslverr;
         psel    <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   // Waits, between edges, until an output equals or leaves a value.
   task wait_for(input integer sel, input [4:0] v, input eq);
      begin
         n = 0;
         do begin
            @(negedge REF_CLK);
            n = n + 1;
            if (ost !== 5'h00)
               op_seen = 1'b1;
         end while ((probe(sel) === v) != eq && n < 4000);
         if ((probe(sel) === v) != eq)
            give_up;
      end
   endtask

   // Reads the state register until one counter field shows a value.
   task poll(input integer lo, input [4:0] v);
      begin
         k = 0;
         do begin
            apb(1'b0, `ICC_OFS_STATES, 32'h0);
            k = k + 1;
         end while (rd[lo +: 5] !== v && k < 60);
         if (rd[lo +: 5] !== v)
            give_up;
      end
   endtask

   // Main sequence.
   initial begin
      ARST_N = 1'b0;
      {psel, penable, pwrite, att, ebusy, run, er, op_seen} = 8'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      rd = 32'h0;
      err_total = 0;
      cmp_count = 0;
      seed = 32'h5c68;
      repeat (6) @(posedge REF_CLK);
      ARST_N <= 1'b1;
      @(negedge REF_CLK);
      chk({16'h0, ist, ost, 4'h0, busy, dsel}, 32'h0);
      apb(1'b1, `ICC_OFS_FLAGS, 32'hFFFFFFFF);
      apb(1'b0, `ICC_OFS_FLAGS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, `ICC_OFS_STATES, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h0C, 32'h0);
      chk({rd[30:0], er}, 32'h1);
      // A store with hold waits for the run level.
      w = ($random(seed) & 32'hFFFFFFC0) | 32'h9;
      apb(1'b1, `ICC_OFS_INSTR, w);
      apb(1'b0, `ICC_OFS_INSTR, 32'h0);
      chk(rd, exp_instr(w));
      repeat (60) @(negedge REF_CLK);
      chk(32'(ist), 32'h0);
      @(posedge REF_CLK) run <= 1'b1;
      wait_for(0, 5'h0F, 1'b1);
      chk(32'(busy), 32'h1);
      wait_for(0, 5'h12, 1'b1);
      chk(32'(busy), 32'h0);
      wait_for(0, 5'h19, 1'b1);
      chk(32'(ost !== 5'h00), 32'h1);
      apb(1'b0, `ICC_OFS_FLAGS, 32'h0);
      chk(32'(rd[`ICC_B_PI1]), 32'h0);
      apb(1'b0, `ICC_OFS_STATES, 32'h0);
      chk(32'(rd[24:20] !== 5'h00), 32'h1);
      // Queue a dismissing jump that writes the index memory at 31.
      apb(1'b1, `ICC_OFS_INSTR, 32'h16);
      wait_for(0, `ICC_S31, 1'b1);
      wait_for(0, `ICC_S31, 1'b0);
      chk(32'(ist), 32'(`ICC_S01));
      wait_for(0, `ICC_S22, 1'b1);
      op_seen = 1'b0;
      wait_for(0, `ICC_S31, 1'b1);
      chk(32'(op_seen), 32'h0);
      wait_for(0, `ICC_S31, 1'b0);
      chk(32'(ist), 32'h0);
      repeat (3) @(negedge REF_CLK);
      chk(32'(dsel), 32'h1);
      apb(1'b0, `ICC_OFS_STATES, 32'h0);
      chk({rd[19:15] !== 5'h00, 26'h0, rd[14:10]}, {1'b1, 26'h0, `ICC_S08});
      poll(15, 5'h00);
      chk(32'(rd[14:10]), 32'(`ICC_S08));
      poll(10, `ICC_S09);
      chk(32'(rd[19:15]), 32'h0);
      // Attention ends the delay cycles; E busy holds off the change cycle.
      @(posedge REF_CLK) ebusy <= 1'b1;
      apb(1'b1, `ICC_OFS_INSTR, 32'h08);
      @(posedge REF_CLK) att <= 1'b1;
      wait_for(2, 5'h00, 1'b1);
      apb(1'b0, `ICC_OFS_FLAGS, 32'h0);
      chk(32'(rd[`ICC_B_PI3]), 32'h1);
      repeat (100) @(negedge REF_CLK);
      apb(1'b0, `ICC_OFS_STATES, 32'h0);
      chk(32'(rd[14:10]), 32'h0);
      @(posedge REF_CLK) {att, ebusy} <= 2'b00;
      wait_for(1, 5'h01, 1'b1);
      apb(1'b0, `ICC_OFS_FLAGS, 32'h0);
      chk(32'(rd[`ICC_B_PI3]), 32'h0);
      wait_for(1, 5'h00, 1'b1);
      wait_for(0, `ICC_S01, 1'b1);
      chk(32'(n < 30), 32'h1);
      // Random instruction words read back.
      repeat (6) begin
         w = $random(seed);
         apb(1'b1, `ICC_OFS_INSTR, w);
         apb(1'b0, `ICC_OFS_INSTR, 32'h0);
         chk(rd, exp_instr(w));
      end
      summarize;
   end
endmodule
